// File: rtl/pec_top.sv
// Operation
// - digital bit 7 runs timer-two clock
// - digital bit 6 enables watchdog
// - digital bit 5 enables multiply-accumulate unit
// - digital bit 4 enables and clocks two-wire
// - digital bit 3 enables serial peripheral interface
// - bits 2,1,0: differential, second, first uart
// - analog blocks powered down after reset
// - analog bits power their analog blocks
// - analog bit 5 stored and forwarded
// - analog registers active when any analog bit
// - all pins inputs after reset
// - output pin carries active peripheral output
// - two-wire pins set direction themselves
// - port 0 upper configuration bits only select the read source
// - port 0 bit 3 feeds second uart receive
// - port 0 bit 2 drives second uart transmit
// - port 0 bits 1,0 feed timer two
// - port 1 low bits carry pwm outputs
// - port 2 upper bits serve serial interface
// - port 2 low bits drive chip selects
// - port 3 bits 7,6 carry two-wire lines
// - port 3 bits 5,4 feed timer, capture
// - port 3 low bits capture, timer, uart
// - outputs show port data, reads show latch on output bits, pins on input bits
// - port 1 low outputs need timer clock, idle compare
`timescale 1ns/1ps
`default_nettype none

module pec_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire pec_pkg::pec_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  input wire pec_pkg::pec_pout_t periph_out,
  output pec_pkg::pec_pin_t periph_in,
  output pec_pkg::pec_dig_t digital_power_enable,
  output pec_pkg::pec_ana_t analog_power_enable,
  output logic analog_regs_active,
  input wire logic [3:0][7:0] pin_in,
  output logic [3:0][7:0] pin_out,
  output logic [3:0][7:0] pin_oe
);

  // ****************************************************************
  // state
  // ****************************************************************
  localparam pec_pkg::pec_state_t RST_STATE = '{
    dig: pec_pkg::PEC_ENABLE_RST,
    ana: pec_pkg::PEC_ENABLE_RST,
    cfg: {4{pec_pkg::PEC_CFG_RST}},
    data: {4{pec_pkg::PEC_PORT_DATA_RST}},
    pout: {4{pec_pkg::PEC_PORT_DATA_RST}},
    poe: {4{pec_pkg::PEC_CFG_RST}},
    pin: pec_pkg::PEC_PIN_IDLE,
    regs_active: 1'b0,
    rdata: pec_pkg::PEC_RDATA_RST
  };

  pec_pkg::pec_state_t st_ff;
  pec_pkg::pec_state_t nxt_st;
  logic [3:0][7:0] out_v;
  logic [3:0][7:0] oe_v;
  logic [7:0] rd_port;

  always_comb begin
    nxt_st = st_ff;
    out_v = st_ff.data;
    oe_v = st_ff.cfg;
    rd_port = pec_pkg::PEC_RDATA_RST;

    // register writes
    if (sfr_req.wr) begin
      unique case (sfr_req.addr)
        pec_pkg::PEC_ADDR_DIGITAL: nxt_st.dig = sfr_req.wdata;
        pec_pkg::PEC_ADDR_ANALOG: nxt_st.ana = sfr_req.wdata;
        pec_pkg::PEC_ADDR_CFG0: nxt_st.cfg[0] = sfr_req.wdata;
        pec_pkg::PEC_ADDR_CFG1: nxt_st.cfg[1] = sfr_req.wdata;
        pec_pkg::PEC_ADDR_CFG2: nxt_st.cfg[2] = sfr_req.wdata;
        pec_pkg::PEC_ADDR_CFG3: nxt_st.cfg[3] = sfr_req.wdata;
        pec_pkg::PEC_ADDR_PORT0: nxt_st.data[0] = sfr_req.wdata;
        pec_pkg::PEC_ADDR_PORT1: nxt_st.data[1] = sfr_req.wdata;
        pec_pkg::PEC_ADDR_PORT2: nxt_st.data[2] = sfr_req.wdata;
        pec_pkg::PEC_ADDR_PORT3: nxt_st.data[3] = sfr_req.wdata;
        default: begin
        end
      endcase
    end

    // ****************************************************************
    // register reads, one cycle after the strobe
    // ****************************************************************
    nxt_st.rdata = pec_pkg::PEC_RDATA_RST;
    if (sfr_req.rd) begin
      unique case (sfr_req.addr)
        pec_pkg::PEC_ADDR_DIGITAL: nxt_st.rdata = st_ff.dig;
        pec_pkg::PEC_ADDR_ANALOG: nxt_st.rdata = st_ff.ana;
        pec_pkg::PEC_ADDR_CFG0: nxt_st.rdata = st_ff.cfg[0];
        pec_pkg::PEC_ADDR_CFG1: nxt_st.rdata = st_ff.cfg[1];
        pec_pkg::PEC_ADDR_CFG2: nxt_st.rdata = st_ff.cfg[2];
        pec_pkg::PEC_ADDR_CFG3: nxt_st.rdata = st_ff.cfg[3];
        pec_pkg::PEC_ADDR_PORT0: begin
          // outputs return the latch, inputs the pin level
          rd_port = (st_ff.cfg[0] & st_ff.data[0])
                  | (~st_ff.cfg[0] & pin_in[0]);
          nxt_st.rdata = rd_port;
        end
        pec_pkg::PEC_ADDR_PORT1: begin
          rd_port = (st_ff.cfg[1] & st_ff.data[1])
                  | (~st_ff.cfg[1] & pin_in[1]);
          nxt_st.rdata = rd_port;
        end
        pec_pkg::PEC_ADDR_PORT2: begin
          rd_port = (st_ff.cfg[2] & st_ff.data[2])
                  | (~st_ff.cfg[2] & pin_in[2]);
          nxt_st.rdata = rd_port;
        end
        pec_pkg::PEC_ADDR_PORT3: begin
          rd_port = (st_ff.cfg[3] & st_ff.data[3])
                  | (~st_ff.cfg[3] & pin_in[3]);
          nxt_st.rdata = rd_port;
        end
        default: nxt_st.rdata = pec_pkg::PEC_RDATA_RST;
      endcase
    end

    nxt_st.regs_active = |st_ff.ana;

    // ****************************************************************
    // port 0
    // ****************************************************************
    // upper bits stay stored but reach no pin
    for (int b = pec_pkg::PEC_P0_UPPER_LSB; b < 8; b++) begin
      oe_v[0][b] = 1'b0;
      out_v[0][b] = 1'b0;
    end
    if (st_ff.dig.second_uart_enable && st_ff.cfg[0][pec_pkg::PEC_P0_TX])
      out_v[0][pec_pkg::PEC_P0_TX] = periph_out.uart1_tx;

    // ****************************************************************
    // port 1: pwm channels share the low nibble
    // ****************************************************************
    for (int c = 0; c < pec_pkg::PEC_P1_PWM_CNT; c++) begin
      // no timer clock, no driver at all on these pins
      oe_v[1][c] = st_ff.cfg[1][c]
                 & st_ff.dig.timer_two_clock_enable;
      if (|periph_out.compare_capture_enable[2*c +: 2])
        out_v[1][c] = periph_out.pwm[c];
    end

    // ****************************************************************
    // port 2: serial peripheral interface
    // ****************************************************************
    if (st_ff.dig.serial_periph_enable) begin
      if (st_ff.cfg[2][pec_pkg::PEC_P2_SDO])
        out_v[2][pec_pkg::PEC_P2_SDO] = periph_out.spi_sdo;
      // clock only driven while the interface runs as master
      if (st_ff.cfg[2][pec_pkg::PEC_P2_SCK] && periph_out.spi_sck_drive)
        out_v[2][pec_pkg::PEC_P2_SCK] = periph_out.spi_sck;
      for (int s = 0; s < 4; s++) begin
        if (st_ff.cfg[2][pec_pkg::PEC_P2_CS_TOP - s])
          out_v[2][pec_pkg::PEC_P2_CS_TOP - s] =
            periph_out.spi_cs[s];
      end
    end

    // ****************************************************************
    // port 3: two-wire lines and first uart
    // ****************************************************************
    if (st_ff.dig.two_wire_enable) begin
      if (st_ff.cfg[3][pec_pkg::PEC_P3_SCL]) begin
        oe_v[3][pec_pkg::PEC_P3_SCL] = periph_out.i2c_scl_oe;
        out_v[3][pec_pkg::PEC_P3_SCL] = periph_out.i2c_scl;
      end
      if (st_ff.cfg[3][pec_pkg::PEC_P3_SDA]) begin
        oe_v[3][pec_pkg::PEC_P3_SDA] = periph_out.i2c_sda_oe;
        out_v[3][pec_pkg::PEC_P3_SDA] = periph_out.i2c_sda;
      end
    end
    if (st_ff.dig.first_uart_enable && st_ff.cfg[3][pec_pkg::PEC_P3_TX])
      out_v[3][pec_pkg::PEC_P3_TX] = periph_out.uart0_tx;

    nxt_st.pout = out_v;
    nxt_st.poe = oe_v;

    // ****************************************************************
    // inputs toward peripherals; idle high when not routed
    // ****************************************************************
    // a disabled peripheral sees idle, the pin stays general purpose
    nxt_st.pin = pec_pkg::PEC_PIN_IDLE;
    if (st_ff.dig.second_uart_enable && !st_ff.cfg[0][pec_pkg::PEC_P0_RX])
      nxt_st.pin.uart1_rx = pin_in[0][pec_pkg::PEC_P0_RX];
    if (st_ff.dig.timer_two_clock_enable) begin
      if (!st_ff.cfg[0][pec_pkg::PEC_P0_TEXT])
        nxt_st.pin.timer2_ext = pin_in[0][pec_pkg::PEC_P0_TEXT];
      if (!st_ff.cfg[0][pec_pkg::PEC_P0_TIN])
        nxt_st.pin.timer2_in = pin_in[0][pec_pkg::PEC_P0_TIN];
    end
    if (st_ff.dig.serial_periph_enable) begin
      if (!st_ff.cfg[2][pec_pkg::PEC_P2_SDI])
        nxt_st.pin.spi_sdi = pin_in[2][pec_pkg::PEC_P2_SDI];
      if (!st_ff.cfg[2][pec_pkg::PEC_P2_SCK])
        nxt_st.pin.spi_sck = pin_in[2][pec_pkg::PEC_P2_SCK];
      if (!st_ff.cfg[2][pec_pkg::PEC_P2_SS])
        nxt_st.pin.spi_ss = pin_in[2][pec_pkg::PEC_P2_SS];
    end
    // timers 0/1 and capture are always clocked, route on config only
    if (!st_ff.cfg[3][pec_pkg::PEC_P3_T1])
      nxt_st.pin.timer1_in = pin_in[3][pec_pkg::PEC_P3_T1];
    if (!st_ff.cfg[3][pec_pkg::PEC_P3_CAP1])
      nxt_st.pin.capture1_in = pin_in[3][pec_pkg::PEC_P3_CAP1];
    if (!st_ff.cfg[3][pec_pkg::PEC_P3_CAP0])
      nxt_st.pin.capture0_in = pin_in[3][pec_pkg::PEC_P3_CAP0];
    if (!st_ff.cfg[3][pec_pkg::PEC_P3_T0])
      nxt_st.pin.timer0_in = pin_in[3][pec_pkg::PEC_P3_T0];
    if (st_ff.dig.first_uart_enable && !st_ff.cfg[3][pec_pkg::PEC_P3_RX])
      nxt_st.pin.uart0_rx = pin_in[3][pec_pkg::PEC_P3_RX];
    // two-wire reads the bus whatever direction it drives
    if (st_ff.dig.two_wire_enable) begin
      nxt_st.pin.i2c_scl = pin_in[3][pec_pkg::PEC_P3_SCL];
      nxt_st.pin.i2c_sda = pin_in[3][pec_pkg::PEC_P3_SDA];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_ff <= RST_STATE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // enable levels double as the clock gates of each peripheral
  assign digital_power_enable = st_ff.dig;
  assign analog_power_enable = st_ff.ana;
  assign analog_regs_active = st_ff.regs_active;
  assign periph_in = st_ff.pin;
  assign pin_out = st_ff.pout;
  assign pin_oe = st_ff.poe;
  assign sfr_rdata = st_ff.rdata;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence wr_dig_s;
    sfr_req.wr && sfr_req.addr == pec_pkg::PEC_ADDR_DIGITAL;
  endsequence

  sequence wr_ana_s;
    sfr_req.wr && sfr_req.addr == pec_pkg::PEC_ADDR_ANALOG;
  endsequence

  sequence rd_port0_s;
    sfr_req.rd && sfr_req.addr == pec_pkg::PEC_ADDR_PORT0;
  endsequence

  sequence rd_dig_s;
    sfr_req.rd && sfr_req.addr == pec_pkg::PEC_ADDR_DIGITAL;
  endsequence

  sequence rd_ana_s;
    sfr_req.rd && sfr_req.addr == pec_pkg::PEC_ADDR_ANALOG;
  endsequence

  dig_write_a: assert property (
    wr_dig_s |=> digital_power_enable == $past(sfr_req.wdata))
    else $error("digital enable write lost");

  ana_active_a: assert property (
    wr_ana_s ##1 1'b1 |=> analog_regs_active == (|$past(sfr_req.wdata, 2)))
    else $error("analog register activity wrong");

  reset_state_a: assert property (
    disable iff (1'b0)
    !rst_n |=> pin_oe == '0 && analog_power_enable == '0
      && digital_power_enable == '0)
    else $error("reset left pins or enables on");

  p0_upper_a: assert property (
    pin_oe[0][7:4] == 4'h0)
    else $error("port 0 upper bits drive a pin");

  sck_drive_a: assert property (
    digital_power_enable.serial_periph_enable
      && st_ff.cfg[2][pec_pkg::PEC_P2_SCK] && periph_out.spi_sck_drive
    |=> pin_out[2][pec_pkg::PEC_P2_SCK] == $past(periph_out.spi_sck))
    else $error("serial clock not on its pin");

  scl_dir_a: assert property (
    digital_power_enable.two_wire_enable
      && st_ff.cfg[3][pec_pkg::PEC_P3_SCL]
    |=> pin_oe[3][pec_pkg::PEC_P3_SCL] == $past(periph_out.i2c_scl_oe))
    else $error("two-wire clock direction not followed");

  pwm_gate_a: assert property (
    !digital_power_enable.timer_two_clock_enable |=> pin_oe[1][3:0] == 4'h0)
    else $error("port 1 low pins driven without timer clock");

  rx_route_a: assert property (
    digital_power_enable.second_uart_enable
      && !st_ff.cfg[0][pec_pkg::PEC_P0_RX]
    |=> periph_in.uart1_rx == $past(pin_in[0][pec_pkg::PEC_P0_RX]))
    else $error("second uart receive not routed");

  gpio_out_a: assert property (
    st_ff.cfg[1][7]
    |=> pin_oe[1][7] && pin_out[1][7] == $past(st_ff.data[1][7]))
    else $error("port data not on output pin");

  port_read_a: assert property (
    rd_port0_s ##0 !st_ff.cfg[0][0] |=> sfr_rdata[0] == $past(pin_in[0][0]))
    else $error("port read does not show pin level");

  dig_read_a: assert property (
    rd_dig_s |=> sfr_rdata == $past(digital_power_enable))
    else $error("digital enable read back wrong");

  ana_read_a: assert property (
    rd_ana_s |=> sfr_rdata == $past(analog_power_enable))
    else $error("analog enable read back wrong");

  regs_idle_a: assert property (
    analog_power_enable == '0 |=> !analog_regs_active)
    else $error("analog registers active with all analog bits clear");

  tx1_route_a: assert property (
    digital_power_enable.second_uart_enable
      && st_ff.cfg[0][pec_pkg::PEC_P0_TX]
    |=> pin_out[0][pec_pkg::PEC_P0_TX] == $past(periph_out.uart1_tx))
    else $error("second uart transmit not on its pin");

  tx1_off_a: assert property (
    !digital_power_enable.second_uart_enable
    |=> pin_out[0][pec_pkg::PEC_P0_TX]
      == $past(st_ff.data[0][pec_pkg::PEC_P0_TX]))
    else $error("disabled uart still drives its pin");

  timer2_in_a: assert property (
    digital_power_enable.timer_two_clock_enable
      && !st_ff.cfg[0][pec_pkg::PEC_P0_TIN]
    |=> periph_in.timer2_in == $past(pin_in[0][pec_pkg::PEC_P0_TIN]))
    else $error("timer two input not routed");

  pwm_out_a: assert property (
    |periph_out.compare_capture_enable[1:0]
    |=> pin_out[1][0] == $past(periph_out.pwm[0]))
    else $error("pwm channel 0 not on its pin");

  p1_gpio_a: assert property (
    periph_out.compare_capture_enable == '0
    |=> pin_out[1][3:0] == $past(st_ff.data[1][3:0]))
    else $error("port 1 low pins not showing port data");

  sdo_route_a: assert property (
    digital_power_enable.serial_periph_enable
      && st_ff.cfg[2][pec_pkg::PEC_P2_SDO]
    |=> pin_out[2][pec_pkg::PEC_P2_SDO] == $past(periph_out.spi_sdo))
    else $error("serial data out not on its pin");

  cs0_route_a: assert property (
    digital_power_enable.serial_periph_enable
      && st_ff.cfg[2][pec_pkg::PEC_P2_CS_TOP]
    |=> pin_out[2][pec_pkg::PEC_P2_CS_TOP] == $past(periph_out.spi_cs[0]))
    else $error("chip select 0 not on its pin");

  spi_idle_a: assert property (
    !digital_power_enable.serial_periph_enable
    |=> periph_in.spi_sdi && periph_in.spi_sck && periph_in.spi_ss)
    else $error("disabled serial interface sees pin levels");

  sda_route_a: assert property (
    digital_power_enable.two_wire_enable
      && st_ff.cfg[3][pec_pkg::PEC_P3_SDA]
    |=> pin_out[3][pec_pkg::PEC_P3_SDA] == $past(periph_out.i2c_sda))
    else $error("two-wire data not on its pin");

  twi_in_a: assert property (
    digital_power_enable.two_wire_enable
    |=> periph_in.i2c_scl == $past(pin_in[3][pec_pkg::PEC_P3_SCL]))
    else $error("two-wire clock level not returned");

  tx0_route_a: assert property (
    digital_power_enable.first_uart_enable
      && st_ff.cfg[3][pec_pkg::PEC_P3_TX]
    |=> pin_out[3][pec_pkg::PEC_P3_TX] == $past(periph_out.uart0_tx))
    else $error("first uart transmit not on its pin");

endmodule

`default_nettype wire

// File: rtl/pec_pkg.sv
package pec_pkg;

  // ****************************************************************
  // special-function register addresses
  // ****************************************************************
  localparam logic [7:0] PEC_ADDR_PORT0 = 8'h80;
  localparam logic [7:0] PEC_ADDR_PORT1 = 8'h90;
  localparam logic [7:0] PEC_ADDR_ANALOG = 8'h92;
  localparam logic [7:0] PEC_ADDR_DIGITAL = 8'h93;
  localparam logic [7:0] PEC_ADDR_CFG0 = 8'h9b;
  localparam logic [7:0] PEC_ADDR_CFG1 = 8'h9c;
  localparam logic [7:0] PEC_ADDR_CFG2 = 8'h9d;
  localparam logic [7:0] PEC_ADDR_CFG3 = 8'h9e;
  localparam logic [7:0] PEC_ADDR_PORT2 = 8'ha0;
  localparam logic [7:0] PEC_ADDR_PORT3 = 8'hb0;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] PEC_ENABLE_RST = 8'h00;
  localparam logic [7:0] PEC_CFG_RST = 8'h00;
  localparam logic [7:0] PEC_PORT_DATA_RST = 8'hff;
  localparam logic [7:0] PEC_RDATA_RST = 8'h00;

  // ****************************************************************
  // pin positions inside the ports
  // ****************************************************************
  localparam int PEC_P0_UPPER_LSB = 4;
  localparam int PEC_P0_RX = 3;
  localparam int PEC_P0_TX = 2;
  localparam int PEC_P0_TEXT = 1;
  localparam int PEC_P0_TIN = 0;
  localparam int PEC_P1_PWM_CNT = 4;
  localparam int PEC_P2_SDI = 7;
  localparam int PEC_P2_SDO = 6;
  localparam int PEC_P2_SCK = 5;
  localparam int PEC_P2_SS = 4;
  localparam int PEC_P2_CS_TOP = 3;
  localparam int PEC_P3_SCL = 7;
  localparam int PEC_P3_SDA = 6;
  localparam int PEC_P3_T1 = 5;
  localparam int PEC_P3_CAP1 = 4;
  localparam int PEC_P3_CAP0 = 3;
  localparam int PEC_P3_T0 = 2;
  localparam int PEC_P3_RX = 1;
  localparam int PEC_P3_TX = 0;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic timer_two_clock_enable;
    logic watchdog_enable;
    logic multiply_acc_enable;
    logic two_wire_enable;
    logic serial_periph_enable;
    logic second_uart_diff_enable;
    logic second_uart_enable;
    logic first_uart_enable;
  } pec_dig_t;

  typedef struct packed {
    logic amplifier_enable;
    logic potentiometer_switch_enable;
    logic current_source_select;
    logic current_source_enable;
    logic ta_output_enable;
    logic converter_enable;
    logic gain_amp_enable;
    logic reference_enable;
  } pec_ana_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } pec_sfr_req_t;

  // signals the peripherals hand to the pin logic
  typedef struct packed {
    logic uart1_tx;
    logic uart0_tx;
    logic [3:0] pwm;
    logic spi_sdo;
    logic spi_sck;
    logic spi_sck_drive;
    logic [3:0] spi_cs;
    logic i2c_scl;
    logic i2c_scl_oe;
    logic i2c_sda;
    logic i2c_sda_oe;
    logic [7:0] compare_capture_enable;
  } pec_pout_t;

  // pin levels routed to the peripherals
  typedef struct packed {
    logic uart1_rx;
    logic timer2_ext;
    logic timer2_in;
    logic spi_sdi;
    logic spi_sck;
    logic spi_ss;
    logic timer1_in;
    logic capture1_in;
    logic capture0_in;
    logic timer0_in;
    logic uart0_rx;
    logic i2c_scl;
    logic i2c_sda;
  } pec_pin_t;

  localparam pec_pin_t PEC_PIN_IDLE = '1;

  typedef struct packed {
    pec_dig_t dig;
    pec_ana_t ana;
    logic [3:0][7:0] cfg;
    logic [3:0][7:0] data;
    logic [3:0][7:0] pout;
    logic [3:0][7:0] poe;
    pec_pin_t pin;
    logic regs_active;
    logic [7:0] rdata;
  } pec_state_t;

endpackage

// File: verification/tb_pec_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_pec_top;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic clk_sys;
  logic rst_n;
  pec_pkg::pec_sfr_req_t req;
  logic [7:0] sfr_rdata;
  pec_pkg::pec_pout_t pout;
  pec_pkg::pec_pin_t pin_fb;
  pec_pkg::pec_dig_t dig;
  pec_pkg::pec_ana_t ana;
  logic regs_act;
  logic [3:0][7:0] pin_in;
  logic [3:0][7:0] pin_out;
  logic [3:0][7:0] pin_oe;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;

  pec_top DUT (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .sfr_req(req),
    .sfr_rdata(sfr_rdata),
    .periph_out(pout),
    .periph_in(pin_fb),
    .digital_power_enable(dig),
    .analog_power_enable(ana),
    .analog_regs_active(regs_act),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe(pin_oe)
  );

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic final_report();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one idle cycle after each write, so pins have settled on return
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    @(negedge clk_sys);
    req.wr = 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    req.addr = a;
    req.rd = 1'b1;
    @(negedge clk_sys);
    chk("rdata", exp, sfr_rdata);
    req.rd = 1'b0;
    @(negedge clk_sys);
    chk("rdata_idle", 8'h00, sfr_rdata);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    chk("dig", 8'h00, dig);
    chk("ana", 8'h00, ana);
    chk("regs_act", 1'b0, regs_act);
    chk("pin_oe", 32'h0, pin_oe);
    // port 0 upper bits reach no pin once out of reset
    chk("pin_out", 32'hffffff0f, pin_out);
    chk("periph_in", 13'h1fff, pin_fb);
    rd(pec_pkg::PEC_ADDR_ANALOG, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rd(pec_pkg::PEC_ADDR_CFG0 + 8'(i), 8'h00);
    end
  endtask

  task automatic t_enables();
    for (int i = 0; i < 8; i++) begin
      wr(pec_pkg::PEC_ADDR_DIGITAL, 8'h01 << i);
      chk("dig", 8'h01 << i, dig);
      rd(pec_pkg::PEC_ADDR_DIGITAL, 8'h01 << i);
      wr(pec_pkg::PEC_ADDR_ANALOG, 8'h01 << i);
      chk("ana", 8'h01 << i, ana);
      chk("regs_act", 1'b1, regs_act);
      rd(pec_pkg::PEC_ADDR_ANALOG, 8'h01 << i);
    end
    wr(pec_pkg::PEC_ADDR_ANALOG, 8'h00);
    chk("regs_act", 1'b0, regs_act);
  endtask

  task automatic t_port0();
    wr(pec_pkg::PEC_ADDR_PORT0, 8'h00);
    wr(pec_pkg::PEC_ADDR_DIGITAL, 8'h82);
    pout.uart1_tx = 1'b1;
    pin_in[0] = 8'h0a;
    wr(pec_pkg::PEC_ADDR_CFG0, 8'hf4);
    rd(pec_pkg::PEC_ADDR_CFG0, 8'hf4);
    chk("p0_oe", 8'h04, pin_oe[0]);
    chk("p0_out", 6'h01, pin_out[0][7:2]);
    chk("p0_in", 3'h6, {pin_fb.uart1_rx, pin_fb.timer2_ext,
                        pin_fb.timer2_in});
    pin_in[0] = 8'h01;
    pout.uart1_tx = 1'b0;
    @(negedge clk_sys);
    chk("p0_tx", 1'b0, pin_out[0][2]);
    chk("p0_in", 3'h1, {pin_fb.uart1_rx, pin_fb.timer2_ext,
                        pin_fb.timer2_in});
    rd(pec_pkg::PEC_ADDR_PORT0, 8'h01);
    // uart disabled: pin falls back to the data latch, receiver idles
    pout.uart1_tx = 1'b1;
    pin_in[0] = 8'h00;
    wr(pec_pkg::PEC_ADDR_DIGITAL, 8'h80);
    chk("p0_tx", 1'b0, pin_out[0][2]);
    chk("p0_rx", 1'b1, pin_fb.uart1_rx);
    wr(pec_pkg::PEC_ADDR_CFG0, 8'h0b);
    chk("p0_oe", 8'h0b, pin_oe[0]);
    chk("p0_in", 2'h3, {pin_fb.timer2_ext, pin_fb.timer2_in});
  endtask

  task automatic t_port1();
    wr(pec_pkg::PEC_ADDR_PORT1, 8'h5a);
    pout.compare_capture_enable = 8'h00;
    pout.pwm = 4'b0101;
    wr(pec_pkg::PEC_ADDR_CFG1, 8'hff);
    chk("p1_oe", 8'hff, pin_oe[1]);
    chk("p1_out", 8'h5a, pin_out[1]);
    pout.compare_capture_enable = 8'h81;
    @(negedge clk_sys);
    chk("p1_out", 8'h53, pin_out[1]);
    wr(pec_pkg::PEC_ADDR_DIGITAL, 8'h00);
    chk("p1_oe", 8'hf0, pin_oe[1]);
    pin_in[1] = 8'h0c;
    wr(pec_pkg::PEC_ADDR_CFG1, 8'hf0);
    rd(pec_pkg::PEC_ADDR_PORT1, 8'h5c);
  endtask

  task automatic t_port2();
    wr(pec_pkg::PEC_ADDR_PORT2, 8'h00);
    wr(pec_pkg::PEC_ADDR_DIGITAL, 8'h08);
    pout.spi_sdo = 1'b1;
    pout.spi_sck = 1'b1;
    pout.spi_sck_drive = 1'b1;
    pout.spi_cs = 4'b0011;
    pin_in[2] = 8'h90;
    wr(pec_pkg::PEC_ADDR_CFG2, 8'h6f);
    chk("p2_oe", 8'h6f, pin_oe[2]);
    chk("p2_out", 8'h6c, pin_out[2] & 8'h6f);
    chk("p2_in", 2'h3, {pin_fb.spi_sdi, pin_fb.spi_ss});
    pin_in[2] = 8'h00;
    pout.spi_cs = 4'b1000;
    pout.spi_sck_drive = 1'b0;
    @(negedge clk_sys);
    chk("p2_out", 8'h41, pin_out[2] & 8'h6f);
    chk("p2_in", 3'h1, {pin_fb.spi_sdi, pin_fb.spi_ss,
                        pin_fb.spi_sck});
    wr(pec_pkg::PEC_ADDR_DIGITAL, 8'h00);
    chk("p2_out", 8'h00, pin_out[2] & 8'h6f);
    chk("p2_in", 1'b1, pin_fb.spi_sdi);
  endtask

  task automatic t_port3();
    wr(pec_pkg::PEC_ADDR_PORT3, 8'h00);
    wr(pec_pkg::PEC_ADDR_DIGITAL, 8'h11);
    pout.i2c_scl = 1'b1;
    pout.i2c_scl_oe = 1'b1;
    pout.i2c_sda = 1'b1;
    pout.i2c_sda_oe = 1'b0;
    pout.uart0_tx = 1'b1;
    pin_in[3] = 8'h2a;
    wr(pec_pkg::PEC_ADDR_CFG3, 8'hc1);
    chk("p3_oe", 8'h81, pin_oe[3]);
    chk("p3_out", 8'h81, pin_out[3] & 8'h81);
    chk("p3_i2c", 2'h0, {pin_fb.i2c_scl, pin_fb.i2c_sda});
    chk("p3_in", 5'h15, {pin_fb.timer1_in, pin_fb.capture1_in,
        pin_fb.capture0_in, pin_fb.timer0_in,
        pin_fb.uart0_rx});
    pout.i2c_scl_oe = 1'b0;
    pout.i2c_sda_oe = 1'b1;
    pin_in[3] = 8'h14;
    @(negedge clk_sys);
    chk("p3_oe", 8'h41, pin_oe[3]);
    chk("p3_sda", 1'b1, pin_out[3][6]);
    chk("p3_in", 5'h0a, {pin_fb.timer1_in, pin_fb.capture1_in,
        pin_fb.capture0_in, pin_fb.timer0_in,
        pin_fb.uart0_rx});
    pin_in[3] = 8'h00;
    wr(pec_pkg::PEC_ADDR_CFG3, 8'h3e);
    chk("p3_oe", 8'h3e, pin_oe[3]);
    chk("p3_in", 5'h1f, {pin_fb.timer1_in, pin_fb.capture1_in,
        pin_fb.capture0_in, pin_fb.timer0_in,
        pin_fb.uart0_rx});
  endtask

  task automatic t_unmapped();
    wr(pec_pkg::PEC_ADDR_DIGITAL, 8'h00);
    wr(8'h91, 8'hff);
    rd(8'h91, 8'h00);
    rd(pec_pkg::PEC_ADDR_DIGITAL, 8'h00);
    rd(pec_pkg::PEC_ADDR_ANALOG, 8'h00);
  endtask

  // ****************************************************************
  // main sequence and hang guard
  // ****************************************************************
  initial begin
    rst_n = 1'b0;
    req = '0;
    pout = '0;
    pin_in = '1;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    t_reset();
    t_enables();
    t_port0();
    t_port1();
    t_port2();
    t_port3();
    t_unmapped();
    final_report();
  end

  // the whole run needs about 135 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      final_report();
    end
  end
endmodule

`default_nettype wire
